/* core/low_power_mode_controller.sv */
/*
 * Low-power mode controller: Sleep, Stop and Standby sequencing, wakeup
 * sources, battery-domain supply selection and the backup register bank.
 * Assumes a 10 MHz clock, Avalon-MM register access, and that the reset
 * pin and watchdog arrive as separate asynchronous sources.
 */
// Our own choices: register access over Avalon-MM and the register addresses.
//
// Contract
// - Sleep halts only the core clock.
// - Any interrupt or event wakes Sleep.
// - Stop gates core clocks, PLL, oscillators.
// - Stop keeps core power, retains state.
// - Setting picks regulator mode during Stop.
// - Enabled event lines end Stop.
// - Standby powers off regulator and oscillators.
// - Standby loses state except backup domain; the code also keeps bksram_q and the IRQ status through it.
// - Reset, watchdog, pin edge, RTC leave Standby.
// - RTC and watchdog clocks keep running.
// - Backup bank survives every reset kind.
// - Backup supply from main, else battery.
// - On battery, events cause no exit.
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller
	import lp_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Avalon-MM slave.
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Core-side events and resets.
	input wire logic i_periph_irq,
	input wire logic i_external_reset_pin_n,
	input wire logic i_independent_watchdog_rst,
	// Pins and always-on sources.
	input wire logic i_wakeup_pin,
	input wire logic i_main_supply_ok,
	input wire wake_src_type i_wake_src,
	// Power controls and status.
	output pwr_ctrl_type o_pwr,
	output logic o_battery_supply_sel,
	output logic [2:0] o_mode,
	output logic o_irq
);

	/*********************************************************************/
	/* Input synchronisation                                             */
	/*********************************************************************/
	localparam int SYNC_W = WAKE_SRC_W + 5;
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	wake_src_type src_s;
	logic pin_s, rstpin_n_s, wdg_s, supply_s, irq_s;

	// The reset pin and supply are synchronised inverted, so that the
	// cleared synchroniser reads as idle and no false event follows reset.
	assign sync_in = {i_wake_src, i_wakeup_pin, ~i_external_reset_pin_n,
		i_independent_watchdog_rst, ~i_main_supply_ok, i_periph_irq};

	lp_sync2 #(.W(SYNC_W)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_d(sync_in),
		.o_q(sync_out)
	);

	assign src_s = sync_out[SYNC_W-1:5];
	assign pin_s = sync_out[4];
	assign rstpin_n_s = ~sync_out[3];
	assign wdg_s = sync_out[2];
	assign supply_s = ~sync_out[1];
	assign irq_s = sync_out[0];

	/*********************************************************************/
	/* Registers                                                         */
	/*********************************************************************/
	pwr_state_type state_q;
	logic [1:0] req_q;
	logic lpreg_q, bksram_q;
	logic [WAKE_SRC_W-1:0] wake_en_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
	logic [31:0] bkp_q [BKP_WORDS];
	logic pin_prev_q, batt_q;
	logic [15:0] por_cnt_q;
	logic wr_acc, rd_acc, bkp_hit, stat_rd;
	logic [4:0] bkp_idx;
	logic [7:0] bkp_off;
	logic [31:0] rd_d;
	logic acc_q;

	// One wait cycle: every access completes on its second edge.
	assign wr_acc = i_avs_write & acc_q;
	assign rd_acc = i_avs_read & acc_q;
	assign bkp_off = i_avs_address - ADDR_BKP_BASE;
	assign bkp_idx = bkp_off[6:2];
	assign bkp_hit = (i_avs_address >= ADDR_BKP_BASE) &&
		(bkp_off < 8'(BKP_BYTES));
	assign stat_rd = rd_acc && (i_avs_address == ADDR_IRQ_STAT);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			acc_q <= 1'b0;
		end else begin
			acc_q <= (i_avs_read | i_avs_write) & ~acc_q;
		end
	end

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] wake_en_wr;

	assign wake_en_wr = be_merge({9'h000, wake_en_q}, i_avs_writedata,
		i_avs_byteenable);

	// Control and mask registers live in the retained core domain.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			lpreg_q <= CTRL_RST[CTRL_LPREG_BIT];
			bksram_q <= CTRL_RST[CTRL_BKSRAM_BIT];
			irq_mask_q <= MASK_RST;
			wake_en_q <= WAKE_EN_RST;
		end else if (state_q == ST_POR) begin
			lpreg_q <= CTRL_RST[CTRL_LPREG_BIT];
			irq_mask_q <= MASK_RST;
			wake_en_q <= WAKE_EN_RST;
		end else if (wr_acc) begin
			unique case (i_avs_address)
				ADDR_CTRL: begin
					if (i_avs_byteenable[0]) begin
						lpreg_q <= i_avs_writedata[CTRL_LPREG_BIT];
						bksram_q <= i_avs_writedata[CTRL_BKSRAM_BIT];
					end
				end
				ADDR_IRQ_MASK: begin
					if (i_avs_byteenable[0]) begin
						irq_mask_q <= i_avs_writedata[IRQ_W-1:0];
					end
				end
				ADDR_WAKE_EN: begin
					wake_en_q <= wake_en_wr[WAKE_SRC_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Backup bank has no reset: it keeps its words through system reset,
	// power reset and Standby, since it sits on the backup supply.
	generate
		for (genvar g = 0; g < BKP_WORDS; g++) begin : g_bkp
			always_ff @(posedge i_clk_sys) begin
				if (wr_acc && bkp_hit && bkp_idx == 5'(g) && !batt_q) begin
					bkp_q[g] <= be_merge(bkp_q[g], i_avs_writedata,
						i_avs_byteenable);
				end
			end
		end
	endgenerate

	/*********************************************************************/
	/* Mode sequencer                                                    */
	/*********************************************************************/
	logic [WAKE_SRC_W-1:0] src_vec;
	logic stop_wake, stby_wake, sleep_wake, req_pulse;
	logic [1:0] req_val;

	assign src_vec = src_s;
	assign req_pulse = wr_acc && (i_avs_address == ADDR_CTRL) &&
		i_avs_byteenable[0];
	assign req_val = i_avs_writedata[CTRL_REQ_LSB +: 2];
	assign sleep_wake = irq_s | (|src_vec);
	assign stop_wake = |(src_vec & wake_en_q);
	assign stby_wake = ~rstpin_n_s | wdg_s | (pin_s & ~pin_prev_q) |
		src_s.rtc_alarm | src_s.rtc_wakeup | src_s.rtc_tamper |
		src_s.rtc_tstamp;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			batt_q <= 1'b0;
		end else begin
			batt_q <= ~supply_s;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			req_q <= REQ_NONE;
		end else if (req_pulse && state_q == ST_RUN) begin
			req_q <= req_val;
		end else begin
			req_q <= REQ_NONE;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_RUN;
			por_cnt_q <= 16'h0000;
		end else if (batt_q) begin
			// On battery only the backup domain is alive; no event exits.
			state_q <= state_q;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					unique case (mode_req_type'(req_q))
						REQ_SLEEP: state_q <= ST_SLEEP;
						REQ_STOP: state_q <= ST_STOP;
						REQ_STBY: state_q <= ST_STBY;
						REQ_NONE: state_q <= ST_RUN;
					endcase
				end
				ST_SLEEP: begin
					if (sleep_wake) begin
						state_q <= ST_RUN;
					end
				end
				ST_STOP: begin
					if (stop_wake) begin
						state_q <= ST_RUN;
					end
				end
				ST_STBY: begin
					if (stby_wake) begin
						state_q <= ST_POR;
						por_cnt_q <= POR_HOLD_CNT;
					end
				end
				ST_POR: begin
					if (por_cnt_q <= 16'h0001) begin
						state_q <= ST_RUN;
					end
					por_cnt_q <= por_cnt_q - 16'h0001;
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	/*********************************************************************/
	/* Power controls                                                    */
	/*********************************************************************/
	pwr_ctrl_type pwr_d;

	always_comb begin
		pwr_d = '0;
		pwr_d.aon_clk_en = 1'b1;
		pwr_d.bksram_keep = bksram_q;
		unique case (state_q)
			ST_RUN: begin
				pwr_d.core_clk_en = 1'b1;
				pwr_d.periph_clk_en = 1'b1;
				pwr_d.pll_en = 1'b1;
				pwr_d.internal_rc_oscillator_en = 1'b1;
				pwr_d.external_crystal_oscillator_en = 1'b1;
				pwr_d.reg_on = 1'b1;
			end
			ST_SLEEP: begin
				pwr_d.periph_clk_en = 1'b1;
				pwr_d.pll_en = 1'b1;
				pwr_d.internal_rc_oscillator_en = 1'b1;
				pwr_d.external_crystal_oscillator_en = 1'b1;
				pwr_d.reg_on = 1'b1;
			end
			ST_STOP: begin
				// Clocks and oscillators off, regulator kept.
				pwr_d.reg_on = 1'b1;
				pwr_d.reg_lp = lpreg_q;
			end
			ST_STBY: begin
				pwr_d.core_rst = 1'b1;
			end
			ST_POR: begin
				pwr_d.reg_on = 1'b1;
				pwr_d.internal_rc_oscillator_en = 1'b1;
				pwr_d.core_rst = 1'b1;
			end
			default: begin
			end
		endcase
		if (batt_q) begin
			pwr_d = '0;
			pwr_d.aon_clk_en = 1'b1;
			pwr_d.bksram_keep = bksram_q;
			pwr_d.core_rst = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_pwr <= '0;
			o_battery_supply_sel <= 1'b0;
			o_mode <= 3'h0;
		end else begin
			o_pwr <= pwr_d;
			o_battery_supply_sel <= batt_q;
			o_mode <= state_q;
		end
	end

	/*********************************************************************/
	/* Interrupts                                                        */
	/*********************************************************************/
	assign irq_set[IRQ_WAKE_SLEEP] = (state_q == ST_SLEEP) & sleep_wake &
		~batt_q;
	assign irq_set[IRQ_WAKE_STOP] = (state_q == ST_STOP) & stop_wake &
		~batt_q;
	assign irq_set[IRQ_WAKE_STBY] = (state_q == ST_POR) &&
		(por_cnt_q == 16'h0001) && !batt_q;
	assign irq_set[IRQ_BATT] = ~batt_q & ~supply_s;

	// A new event in the clearing read's cycle stays set.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_set;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	/*********************************************************************/
	/* Read path                                                         */
	/*********************************************************************/
	always_comb begin
		rd_d = RD_UNMAPPED;
		if (bkp_hit) begin
			rd_d = bkp_q[bkp_idx];
		end else begin
			unique case (i_avs_address)
				ADDR_CTRL: rd_d = {27'h000_0000, 1'b0, bksram_q,
					lpreg_q, 2'b00};
				ADDR_STATUS: rd_d = {27'h000_0000, batt_q, 1'b0,
					state_q};
				ADDR_IRQ_STAT: rd_d = {28'h000_0000, irq_stat_q};
				ADDR_IRQ_MASK: rd_d = {28'h000_0000, irq_mask_q};
				ADDR_WAKE_EN: rd_d = {9'h000, wake_en_q};
				default: rd_d = RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0000_0000;
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_readdata <= rd_d;
			o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~acc_q);
		end
	end

endmodule
`default_nettype wire

/* common/lp_ctrl_pkg.sv */
/*
 * Package for the low-power mode controller: register offsets, field
 * positions, reset values, timing counts and the carrier structs.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package lp_ctrl_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h10;
	localparam logic [7:0] ADDR_BKP_BASE = 8'h40;

	// Control register fields.
	localparam int CTRL_REQ_LSB = 0;
	localparam int CTRL_LPREG_BIT = 2;
	localparam int CTRL_BKSRAM_BIT = 3;
	localparam int CTRL_SLEEP_ON_BIT = 4;

	// Interrupt status bits.
	localparam int IRQ_WAKE_SLEEP = 0;
	localparam int IRQ_WAKE_STOP = 1;
	localparam int IRQ_WAKE_STBY = 2;
	localparam int IRQ_BATT = 3;
	localparam int IRQ_W = 4;

	// Backup register bank: 80 bytes of 32-bit words.
	localparam int BKP_BYTES = 80;
	localparam int BKP_WORDS = BKP_BYTES / 4;
	localparam int EXT_LINES = 16;
	localparam int WAKE_SRC_W = 23;

	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
	localparam logic [WAKE_SRC_W-1:0] WAKE_EN_RST = 23'h00_0000;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	// Power-on restart hold time after Standby exit.
	localparam int CLK_HZ = 10_000_000;
	localparam int POR_HOLD_US = 100;
	localparam int POR_HOLD_CYC = (POR_HOLD_US * (CLK_HZ / 1_000_000));
	localparam logic [15:0] POR_HOLD_CNT = 16'(POR_HOLD_CYC);

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_SLEEP = 3'b001,
		ST_STOP = 3'b010,
		ST_STBY = 3'b011,
		ST_POR = 3'b100
	} pwr_state_type;

	typedef enum logic [1:0] {
		REQ_NONE = 2'b00,
		REQ_SLEEP = 2'b01,
		REQ_STOP = 2'b10,
		REQ_STBY = 2'b11
	} mode_req_type;

	// Clock, oscillator and supply controls toward the analog domain.
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic pll_en;
		logic internal_rc_oscillator_en;
		logic external_crystal_oscillator_en;
		logic reg_on;
		logic reg_lp;
		logic core_rst;
		logic bksram_keep;
		logic aon_clk_en;
	} pwr_ctrl_type;

	// Wakeup sources from the always-on world.
	typedef struct packed {
		logic [EXT_LINES-1:0] ext_line;
		logic supply_level_detector;
		logic rtc_alarm;
		logic rtc_wakeup;
		logic rtc_tamper;
		logic rtc_tstamp;
		logic usb_wakeup;
		logic eth_wakeup;
	} wake_src_type;

endpackage

/* core/lp_sync2.sv */
/*
 * Two-flop synchroniser, one per bit, for inputs from pins and the
 * always-on domain. Assumes one system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module lp_sync2 #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Data.
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			o_q <= '0;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* test/lp_far_side.sv */
/*
 * Far-side model: wakeup pin, reset pin and main supply.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lp_far_side (
	// Clock.
	input wire logic i_clk_sys,
	// Pins.
	output logic o_wakeup_pin,
	output logic o_external_reset_pin_n,
	output logic o_main_supply_ok
);
	// ****************
	// Pin drivers.
	// ****************
	initial begin
		o_wakeup_pin = 1'b0;
		o_external_reset_pin_n = 1'b1;
		o_main_supply_ok = 1'b1;
	end
	// A long delay models a slow partner; the pin stays low until then.
	task automatic wake(input int dly);
		repeat (dly) @(posedge i_clk_sys);
		o_wakeup_pin <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		o_wakeup_pin <= 1'b0;
	endtask
	task automatic pin_reset();
		o_external_reset_pin_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		o_external_reset_pin_n <= 1'b1;
	endtask
	task automatic supply(input logic ok);
		o_main_supply_ok <= ok;
	endtask
endmodule
`default_nettype wire

/* test/lp_ctrl_properties.sv */
/*
 * Checker for the low-power mode controller, bound to its top ports.
 * Assumes one clock; o_pwr and o_mode are registered on the same edge from state_q.
 */
`timescale 1ns/1ps
`default_nettype none
module lp_ctrl_checker
	import lp_ctrl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_periph_irq,
	input wire logic i_main_supply_ok,
	input wire pwr_ctrl_type o_pwr,
	input wire logic o_battery_supply_sel,
	input wire logic [2:0] o_mode
);
	// ****************
	// Properties.
	// ****************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Mode must be steady one cycle; o_pwr and o_mode update on the same edge.
	AST_SLEEP_CLK: assert property (
		o_mode == ST_SLEEP && $past(o_mode) == ST_SLEEP && !o_pwr.core_rst
		|-> !o_pwr.core_clk_en && o_pwr.periph_clk_en)
		else $error("sleep clocks wrong");
	AST_SLEEP_WAKE: assert property (
		o_mode == ST_SLEEP && i_periph_irq && !o_battery_supply_sel
		|-> ##[1:8] o_mode == ST_RUN)
		else $error("sleep not woken");
	AST_STOP_CLK: assert property (
		o_mode == ST_STOP && $past(o_mode) == ST_STOP && !o_pwr.core_rst
		|-> !o_pwr.core_clk_en && !o_pwr.periph_clk_en && !o_pwr.pll_en
		&& !o_pwr.internal_rc_oscillator_en && o_pwr.reg_on
		&& !o_pwr.external_crystal_oscillator_en)
		else $error("stop controls wrong");
	AST_STBY_OFF: assert property (
		o_mode == ST_STBY && $past(o_mode) == ST_STBY && !o_battery_supply_sel
		|-> !o_pwr.reg_on && !o_pwr.pll_en && !o_pwr.internal_rc_oscillator_en
		&& !o_pwr.external_crystal_oscillator_en)
		else $error("standby controls wrong");
	AST_STBY_EXIT: assert property (
		$past(o_mode) == ST_STBY && o_mode != ST_STBY |-> o_mode == ST_POR)
		else $error("standby exit not through restart");
	AST_POR_HOLD: assert property (
		o_mode == ST_POR && $past(o_mode) == ST_POR |-> o_pwr.core_rst)
		else $error("core not held in restart");
	AST_AON: assert property (
		!$past(i_rst) && !$past(i_rst, 2) |-> o_pwr.aon_clk_en)
		else $error("always-on clock stopped");
	AST_BATT_SEL: assert property (
		$fell(i_main_supply_ok) |-> ##[1:4] o_battery_supply_sel)
		else $error("battery not selected");
	AST_BATT_HOLD: assert property (
		o_battery_supply_sel && $past(o_battery_supply_sel) |-> $stable(o_mode))
		else $error("mode moved on battery");
endmodule
bind low_power_mode_controller lp_ctrl_checker u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_periph_irq(i_periph_irq),
	.i_main_supply_ok(i_main_supply_ok), .o_pwr(o_pwr),
	.o_battery_supply_sel(o_battery_supply_sel), .o_mode(o_mode));
`default_nettype wire

/* test/tb_top.sv */
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes a 10 MHz clock and one wait state per register access.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lp_ctrl_pkg::*;
	// ****************
	// Bench.
	// ****************
	logic clk, rst, rd, wr, pirq, wdog, waitreq, bsel, irq, wpin, external_reset_pin, sup;
	logic [7:0] adr;
	logic [31:0] wd, rdv, rdata;
	logic [3:0] be;
	logic [2:0] mode;
	wake_src_type src;
	pwr_ctrl_type pwr;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	lp_far_side far (.i_clk_sys(clk), .o_wakeup_pin(wpin),
		.o_external_reset_pin_n(external_reset_pin), .o_main_supply_ok(sup));
	low_power_mode_controller DUT (.i_clk_sys(clk), .i_rst(rst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_periph_irq(pirq), .i_external_reset_pin_n(external_reset_pin),
		.i_independent_watchdog_rst(wdog), .i_wakeup_pin(wpin),
		.i_main_supply_ok(sup), .i_wake_src(src), .o_pwr(pwr),
		.o_battery_supply_sel(bsel), .o_mode(mode), .o_irq(irq));
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= r;
		wr <= !r;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (waitreq !== 1'b0);
		rdv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		chk(nm, e, rdv);
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) @(posedge clk);
		chk("mode", 32'(m), 32'(mode));
	endtask
	// The ceiling covers four restarts of 1000 cycles with margin.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 8000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		{rd, wr, pirq, wdog} = 4'h0;
		adr = 8'h00;
		wd = 32'h0;
		be = 4'hF;
		src = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rchk("ctrl", ADDR_CTRL, 32'h0);
		rchk("unmapped", 8'hFC, RD_UNMAPPED);
		bus(1'b0, ADDR_BKP_BASE, 32'h1234_5678);
		be <= 4'h3;
		bus(1'b0, ADDR_BKP_BASE, 32'hA5A5_A5A5);
		be <= 4'hF;
		rchk("bkp", ADDR_BKP_BASE, 32'h1234_A5A5);
		$display("test registers done");
		bus(1'b0, ADDR_CTRL, 32'h1);
		wait_mode(ST_SLEEP, 20);
		pirq <= 1'b1;
		wait_mode(ST_RUN, 20);
		pirq <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq_masked", 32'h0, 32'(irq));
		bus(1'b0, ADDR_IRQ_MASK, 32'hF);
		repeat (3) @(posedge clk);
		chk("irq_enabled", 32'h1, 32'(irq));
		rchk("irq_stat", ADDR_IRQ_STAT, 32'h1);
		rchk("irq_clear", ADDR_IRQ_STAT, 32'h0);
		bus(1'b0, ADDR_IRQ_MASK, 32'h0);
		$display("test sleep done");
		bus(1'b0, ADDR_WAKE_EN, 32'h80);
		for (int lp = 0; lp < 2; lp++) begin
			bus(1'b0, ADDR_CTRL, 32'(2 + 4 * lp));
			wait_mode(ST_STOP, 20);
			repeat (3) @(posedge clk);
			chk("reg_lp", 32'(lp), 32'(pwr.reg_lp));
			src.ext_line <= 16'h0002;
			repeat (10) @(posedge clk);
			chk("stop_held", 32'(ST_STOP), 32'(mode));
			src.ext_line <= 16'h0001;
			wait_mode(ST_RUN, 20);
			src <= '0;
			rchk("kept", ADDR_WAKE_EN, 32'h80);
		end
		rchk("stop_stat", ADDR_IRQ_STAT, 32'h2);
		$display("test stop done");
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, ADDR_WAKE_EN, 32'h80);
			bus(1'b0, ADDR_CTRL, 32'hB);
			wait_mode(ST_STBY, 20);
			if (k == 0) far.wake(20);
			else if (k == 1) far.pin_reset();
			else if (k == 2) wdog <= 1'b1;
			else src.rtc_alarm <= 1'b1;
			wait_mode(ST_POR, 40);
			wdog <= 1'b0;
			src <= '0;
			repeat (900) @(posedge clk);
			chk("por_hold", 32'(ST_POR), 32'(mode));
			wait_mode(ST_RUN, 200);
			rchk("lost", ADDR_WAKE_EN, 32'h0);
			rchk("bkp_stby", ADDR_BKP_BASE, 32'h1234_A5A5);
			rchk("stby_stat", ADDR_IRQ_STAT, 32'h4);
		end
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rchk("bkp_rst", ADDR_BKP_BASE, 32'h1234_A5A5);
		$display("test standby done");
		bus(1'b0, ADDR_WAKE_EN, 32'h80);
		bus(1'b0, ADDR_CTRL, 32'h2);
		wait_mode(ST_STOP, 20);
		far.supply(1'b0);
		repeat (6) @(posedge clk);
		chk("bsel", 32'h1, 32'(bsel));
		src <= '{ext_line: 16'h0001, rtc_alarm: 1'b1, default: 1'b0};
		repeat (10) @(posedge clk);
		chk("batt_hold", 32'(ST_STOP), 32'(mode));
		far.supply(1'b1);
		repeat (6) @(posedge clk);
		chk("bsel_off", 32'h0, 32'(bsel));
		wait_mode(ST_RUN, 20);
		src <= '0;
		rchk("batt_stat", ADDR_IRQ_STAT, 32'hA);
		$display("test battery done");
		close_out();
	end
endmodule
`default_nettype wire
